// *** logic/srio_event_and_reset_pins.sv ***
// Purpose: Port reset output and multicast event pin logic behind an AHB-Lite register file.
// Assumes: Link inputs are synchronous to hclk; the event pin is asynchronous.
// Notes: Registers are zero wait state; read data is taken in the address phase.
// Contract
// - Drive port reset low after four consecutive reset symbols when self reset enabled.
// - Reset pin drives normally and becomes an input only during scan test mode.
// - Port reset output is active low and asserts without waiting for a clock edge.
// - Event pin direction follows the direction select bit of device control.
// - As input, every rising and falling pin edge outside a running sequence sends a multicast event symbol.
// - Symbol command comes from forwarding, multicast select and trigger enable mask.
// - Several enabled trigger commands produce several symbols, each with a different command.
// - As output, the pin toggles on each received event whose command is capture enabled.
// - Device reset returns all block state, including event and reset output, to reset.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sideband_consts.svh"
module srio_event_and_reset_pins
    import sideband_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic rx_sym_valid,
    input wire logic rx_sym_is_reset,
    input wire logic rx_sym_is_event,
    input wire logic [2:0] rx_event_cmd,
    output logic tx_event_valid,
    output logic [2:0] tx_event_cmd,
    input wire logic tx_event_ready,
    input wire logic scan_mode,
    input wire logic port_reset_in,
    output logic port_reset_out_n,
    output logic port_reset_oe_n,
    input wire logic event_pin_in,
    output logic event_pin_out,
    output logic event_pin_oe_n,
    output logic irq
);
    localparam int HOLD_CYCLES = (`RST_HOLD_NS * `CLK_MHZ + 999) / 1000;
    localparam int HOLD_M1 = HOLD_CYCLES - 1;

    logic [1:0] dev_ctrl_q;
    logic [1:0] fwd_ctrl_q;
    logic [7:0] trig_en_q;
    logic [7:0] cap_en_q;
    logic [3:0] irq_status_q;
    logic [3:0] irq_enable_q;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_mux;
    logic rd_take;
    logic [2:0] cnt_q;
    logic fire;
    logic rst_active_q;
    logic [7:0] hold_q;
    logic [2:0] sync_q;
    logic edge_det;
    logic [7:0] pend_q;
    logic [7:0] pend_next;
    logic [7:0] load_mask;
    logic [2:0] cmd_q;
    logic event_pin_q;
    logic rx_toggle;
    logic tx_accept;
    tx_state_t state_q;

    // Lowest set bit of a command mask.
    function automatic event_cmd_t lowest(input logic [7:0] m);
        event_cmd_t r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // The slave never stalls and never errors.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;

    // Read mux; unmapped and write-only offsets read as zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr)
            `OFS_DEV_CTRL: rd_mux[1:0] = dev_ctrl_q;
            `OFS_FWD_CTRL: rd_mux[1:0] = fwd_ctrl_q;
            `OFS_TRIG_EN: rd_mux[7:0] = trig_en_q;
            `OFS_CAP_EN: rd_mux[7:0] = cap_en_q;
            `OFS_IRQ_STATUS: rd_mux[3:0] = irq_status_q;
            `OFS_IRQ_ENABLE: rd_mux[3:0] = irq_enable_q;
            `OFS_PIN_STATUS: rd_mux[4:0] = {state_q == ST_SEND, port_reset_in, rst_active_q, event_pin_q, sync_q[2]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is registered in the address phase and stands in the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            hrdata <= rd_mux;
        end
    end

    // Write address phase is captured and applied in the following data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr;
        end
    end

    // Software control registers.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dev_ctrl_q <= `RST_DEV_CTRL;
            fwd_ctrl_q <= `RST_FWD_CTRL;
            trig_en_q <= `RST_CMD_MASK;
            cap_en_q <= `RST_CMD_MASK;
            irq_enable_q <= `RST_IRQ;
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == `OFS_DEV_CTRL) dev_ctrl_q <= hwdata[1:0];
            if (wr_addr_q == `OFS_FWD_CTRL) fwd_ctrl_q <= hwdata[1:0];
            if (wr_addr_q == `OFS_TRIG_EN) trig_en_q <= hwdata[7:0];
            if (wr_addr_q == `OFS_CAP_EN) cap_en_q <= hwdata[7:0];
            if (wr_addr_q == `OFS_IRQ_ENABLE) irq_enable_q <= hwdata[3:0];
        end
    end

    // Sticky status; a new event in the clear cycle wins over the clear.
    assign irq_clr = (wr_pend_q && wr_addr_q == `OFS_IRQ_CLEAR) ? hwdata[3:0] : 4'h0;
    assign irq_set = {edge_det && state_q == ST_SEND && !dev_ctrl_q[`BIT_DIR_SEL],
        rx_toggle, tx_accept && pend_next == 8'h00, fire};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status_q <= `RST_IRQ;
        end
        else
        begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_status_q & irq_enable_q);

    // Consecutive reset symbol counter; any other symbol breaks the run.
    assign fire = rx_sym_valid && rx_sym_is_reset && dev_ctrl_q[`BIT_SELF_RESET_ENABLE]
        && cnt_q == 3'(`RST_SYM_COUNT - 1);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 3'h0;
        end
        else if (rx_sym_valid)
        begin
            if (!rx_sym_is_reset)
                cnt_q <= 3'h0;
            else if (cnt_q != 3'(`RST_SYM_COUNT - 1))
                cnt_q <= cnt_q + 3'h1;
        end
    end

    // Reset pulse is held for a fixed time after the fourth symbol.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_active_q <= 1'b0;
            hold_q <= 8'h00;
        end
        else if (fire)
        begin
            rst_active_q <= 1'b1;
            hold_q <= 8'h00;
        end
        else if (rst_active_q)
        begin
            hold_q <= hold_q + 8'h01;
            if (hold_q == 8'(HOLD_M1)) rst_active_q <= 1'b0;
        end
    end

    // The fire term goes straight to the pin so assertion needs no clock edge.
    assign port_reset_out_n = !(rst_active_q || fire);
    assign port_reset_oe_n = scan_mode;

    // Two-flop synchroniser and a third stage for edge detection.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_q <= 3'h0;
        end
        else
        begin
            sync_q <= {sync_q[1:0], event_pin_in};
        end
    end
    assign edge_det = sync_q[1] ^ sync_q[2];

    // Commands for one edge: all enabled ones, or only the lowest when multicast select is off.
    assign load_mask = !fwd_ctrl_q[`BIT_FORWARD_A] ? 8'h00 :
        fwd_ctrl_q[`BIT_MULTI_SEL] ? trig_en_q : (trig_en_q & (~trig_en_q + 8'h01));
    assign tx_accept = state_q == ST_SEND && tx_event_ready;
    assign pend_next = pend_q & ~(8'h01 << cmd_q);
    assign tx_event_valid = state_q == ST_SEND;
    assign tx_event_cmd = cmd_q;

    // Event sender; an edge during a running sequence is dropped and flagged.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            pend_q <= 8'h00;
            cmd_q <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (edge_det && !dev_ctrl_q[`BIT_DIR_SEL] && load_mask != 8'h00)
                    begin
                        state_q <= ST_SEND;
                        pend_q <= load_mask;
                        cmd_q <= lowest(load_mask);
                    end
                end
                ST_SEND:
                begin
                    if (tx_event_ready)
                    begin
                        pend_q <= pend_next;
                        cmd_q <= lowest(pend_next);
                        if (pend_next == 8'h00) state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Output mode: captured event commands toggle the pin.
    assign rx_toggle = rx_sym_valid && rx_sym_is_event && dev_ctrl_q[`BIT_DIR_SEL] && cap_en_q[rx_event_cmd];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            event_pin_q <= 1'b0;
        end
        else if (rx_toggle)
        begin
            event_pin_q <= !event_pin_q;
        end
    end
    assign event_pin_out = event_pin_q;
    assign event_pin_oe_n = !dev_ctrl_q[`BIT_DIR_SEL];

    // Checks on the link and pin behaviour.
    a_reset_on_fourth: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_sym_valid && rx_sym_is_reset && cnt_q == 3'h3 && dev_ctrl_q[1] |-> !port_reset_out_n)
        else $error("port reset not asserted on fourth reset symbol");
    a_reset_needs_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        !dev_ctrl_q[1] && !rst_active_q |-> port_reset_out_n)
        else $error("port reset asserted while self reset disabled");
    a_reset_no_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(rst_active_q) |-> !$past(port_reset_out_n))
        else $error("port reset waited for a clock edge");
    a_reset_pin_dir: assert property (@(posedge hclk) disable iff (!hresetn)
        port_reset_oe_n == scan_mode)
        else $error("port reset pin direction wrong");
    a_event_pin_dir: assert property (@(posedge hclk) disable iff (!hresetn)
        event_pin_oe_n == !dev_ctrl_q[0] && (dev_ctrl_q[0] || !rx_toggle))
        else $error("event pin direction wrong");
    a_edge_starts_seq: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_IDLE && edge_det && !dev_ctrl_q[0] && fwd_ctrl_q[0] && trig_en_q != 8'h00
        |=> tx_event_valid && trig_en_q[tx_event_cmd])
        else $error("pin edge did not start an event sequence");
    a_cmd_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_event_valid |-> pend_q[tx_event_cmd])
        else $error("event command not enabled");
    a_cmds_distinct: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_accept ##1 tx_event_valid |-> tx_event_cmd > $past(tx_event_cmd))
        else $error("event command repeated within a sequence");
    a_pin_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_toggle |=> event_pin_out != $past(event_pin_out))
        else $error("event pin did not toggle");
    a_edge_synced: assert property (@(posedge hclk) disable iff (!hresetn)
        ##3 edge_det |-> $past(event_pin_in, 2) != $past(event_pin_in, 3))
        else $error("edge detected without a synchronised change");
    a_reset_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(rst_active_q) && !fire |-> rst_active_q [*8])
        else $error("port reset pulse too short");
    c_self_reset: cover property (@(posedge hclk) disable iff (!hresetn) fire);
    c_multi_cmd: cover property (@(posedge hclk) disable iff (!hresetn) tx_accept ##1 tx_event_valid);
    c_pin_toggle: cover property (@(posedge hclk) disable iff (!hresetn) rx_toggle);
endmodule
`default_nettype wire

// *** logic/sideband_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing of the sideband pin block.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one word per register.
// Notes: Definitions only.
`ifndef SIDEBAND_CONSTS_SVH
`define SIDEBAND_CONSTS_SVH
`define OFS_DEV_CTRL 8'h00
`define OFS_FWD_CTRL 8'h04
`define OFS_TRIG_EN 8'h08
`define OFS_CAP_EN 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_CLEAR 8'h14
`define OFS_IRQ_ENABLE 8'h18
`define OFS_PIN_STATUS 8'h1C
`define BIT_DIR_SEL 0
`define BIT_SELF_RESET_ENABLE 1
`define BIT_FORWARD_A 0
`define BIT_MULTI_SEL 1
`define IRQ_RESET_FIRED 0
`define IRQ_SEQ_DONE 1
`define IRQ_PIN_TOGGLED 2
`define IRQ_EDGE_LOST 3
`define RST_DEV_CTRL 2'h0
`define RST_FWD_CTRL 2'h0
`define RST_CMD_MASK 8'h00
`define RST_IRQ 4'h0
`define RST_SYM_COUNT 4
`define RST_HOLD_NS 1000
`define CLK_MHZ 100
`endif

// *** logic/sideband_pkg.sv ***
// Purpose: Types shared by the sideband pin block.
// Assumes: Nothing beyond the constants header.
// Notes: Types only.
package sideband_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_SEND} tx_state_t;
    typedef logic [2:0] event_cmd_t;
endpackage

// *** verification/link_partner.sv ***
// Purpose: Link partner model that sends control symbols and takes event symbols.
// Assumes: Symbols are synchronous to the device clock.
// Notes: Between symbols the lines carry the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module link_partner
(
    input wire logic clk,
    input wire logic slow,
    output logic rx_sym_valid,
    output logic rx_sym_is_reset,
    output logic rx_sym_is_event,
    output logic [2:0] rx_event_cmd,
    output logic tx_event_ready
);
    // Lines start idle so the first edge sees no symbol.
    initial
    begin
        rx_sym_valid = 1'b0;
        rx_sym_is_reset = 1'b0;
        rx_sym_is_event = 1'b0;
        rx_event_cmd = 3'h0;
    end
    // Takes offered symbols at once, or every other cycle when slow.
    always @(posedge clk) tx_event_ready <= slow ? ~tx_event_ready : 1'b1;
    // Offers one symbol for one cycle, then scrambles the lines.
    task automatic send(input logic r, input logic e, input logic [2:0] c);
        @(posedge clk);
        rx_sym_valid <= 1'b1;
        rx_sym_is_reset <= r;
        rx_sym_is_event <= e;
        rx_event_cmd <= c;
        @(posedge clk);
        rx_sym_valid <= 1'b0;
        rx_sym_is_reset <= ~r;
        rx_sym_is_event <= ~e;
        rx_event_cmd <= ~c;
    endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the sideband pin block.
// Assumes: One clock at 100 MHz; reset held for five cycles.
// Notes: Drivers queue expected results and a monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk, hresetn, hsel, hwrite, rd_dp, scan_mode, pin_drv, slow, e;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rq[$];
    logic [31:0] seed = 32'h0000_64ca;
    logic [2:0] tq[$];
    logic hreadyout, hresp, rxv, rxr, rxe, txv, txr, ro_n, ro_oe_n, po, po_oe_n, irq;
    logic [2:0] rxc, txc;
    int errors = 0;
    int n_compared = 0;
    wire logic ev_in = po_oe_n ? pin_drv : po;
    // A released reset pin shows the inverse of the level last driven on it.
    wire logic rs_in = ro_oe_n ? ~ro_n : ro_n;
    srio_event_and_reset_pins srio_event_and_reset_pins_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_sym_valid(rxv), .rx_sym_is_reset(rxr),
        .rx_sym_is_event(rxe), .rx_event_cmd(rxc), .tx_event_valid(txv), .tx_event_cmd(txc),
        .tx_event_ready(txr), .scan_mode(scan_mode), .port_reset_in(rs_in), .port_reset_out_n(ro_n),
        .port_reset_oe_n(ro_oe_n), .event_pin_in(ev_in), .event_pin_out(po), .event_pin_oe_n(po_oe_n),
        .irq(irq));
    link_partner link_partner_inst (.clk(hclk), .slow(slow), .rx_sym_valid(rxv), .rx_sym_is_reset(rxr),
        .rx_sym_is_event(rxe), .rx_event_cmd(rxc), .tx_event_ready(txr));
    // Next value of the random sequence.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single word transfer; a read queues its expected data.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'd2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp <= ~w;
        if (!w)
            rq.push_back(x);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task results;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Random trigger mask, one pin edge, expected commands in rising order.
    task automatic tx(input logic s);
        logic [7:0] m;
        logic f;
        int k;
        seed = lfsr(seed);
        m = seed[7:0] | 8'h10;
        f = 1'b0;
        bus(1'b1, 8'h04, {30'd0, s, 1'b1}, 0);
        bus(1'b1, 8'h08, {24'd0, m}, 0);
        for (k = 0; k < 8; k++)
            if (m[k] && (s || !f))
            begin
                tq.push_back(k[2:0]);
                f = 1'b1;
            end
        @(posedge hclk);
        pin_drv <= ~pin_drv;
        for (k = 0; k < 300 && (tq.size() > 0 || k < 12); k++) @(posedge hclk);
        check(32'(tq.size()), 0, "left");
    endtask
    // Monitor of read data and of event symbols taken by the partner.
    always @(posedge hclk)
    begin
        if (rd_dp)
        begin
            check(hrdata, rq.pop_front(), "rdata");
            check(hresp, 0, "hresp");
        end
        if (txv && txr)
            check({29'd0, txc}, tq.size() > 0 ? {29'd0, tq.pop_front()} : 32'hff, "cmd");
    end
    // Clock of 10 ns.
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Watchdog against a hang.
    initial
    begin
        repeat (20000) @(posedge hclk);
        errors++;
        results;
    end
    // Main sequence of scenarios.
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'd2;
        hwdata = 32'h0000_0000;
        rd_dp = 1'b0;
        scan_mode = 1'b0;
        pin_drv = 1'b0;
        slow = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 0, 0);
        bus(1'b1, 8'h20, 32'hffff_ffff, 0);
        bus(1'b0, 8'h20, 0, 0);
        bus(1'b1, 8'h00, 32'h0000_0002, 0);
        bus(1'b1, 8'h18, 32'h0000_0001, 0);
        repeat (3) link_partner_inst.send(1'b1, 1'b0, 3'h0);
        link_partner_inst.send(1'b0, 1'b1, 3'h0);
        repeat (3) link_partner_inst.send(1'b1, 1'b0, 3'h0);
        #1 check(ro_n, 1, "rst_n");
        link_partner_inst.send(1'b1, 1'b0, 3'h0);
        #1 check(ro_n, 0, "rst_n");
        check(irq, 1, "irq");
        repeat (50) @(posedge hclk);
        #1 check(ro_n, 0, "rst_n");
        repeat (52) @(posedge hclk);
        #1 check(ro_n, 1, "rst_n");
        bus(1'b0, 8'h10, 0, 1);
        bus(1'b1, 8'h14, 1, 0);
        #1 check(irq, 0, "irq");
        repeat (4) link_partner_inst.send(1'b1, 1'b0, 3'h0);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1 check(ro_n, 1, "rst_n");
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 0, 0);
        repeat (4) link_partner_inst.send(1'b1, 1'b0, 3'h0);
        #1 check(ro_n, 1, "rst_n");
        @(posedge hclk) scan_mode <= 1'b1;
        #1 check(ro_oe_n, 1, "rst_oe");
        bus(1'b0, 8'h1C, 0, 32'h0000_0000);
        @(posedge hclk) scan_mode <= 1'b0;
        #1 check(ro_oe_n, 0, "rst_oe");
        bus(1'b0, 8'h1C, 0, 32'h0000_0008);
        tx(1'b1);
        slow <= 1'b1;
        tx(1'b1);
        tx(1'b0);
        slow <= 1'b0;
        tx(1'b0);
        bus(1'b0, 8'h10, 0, 32'h0000_0002);
        bus(1'b1, 8'h00, 1, 0);
        #1 check(po_oe_n, 0, "pin_oe");
        bus(1'b1, 8'h0C, 32'h0000_0020, 0);
        e = 1'b0;
        for (int c = 0; c < 8; c++)
        begin
            link_partner_inst.send(1'b0, 1'b1, c[2:0]);
            e = (c == 5) ? ~e : e;
            #1 check(po, e, "pin");
        end
        link_partner_inst.send(1'b0, 1'b0, 3'h5);
        #1 check(po, e, "pin");
        bus(1'b0, 8'h10, 0, 32'h0000_0006);
        @(posedge hclk) pin_drv <= ~pin_drv;
        repeat (12) @(posedge hclk);
        results;
    end
endmodule
`default_nettype wire
